// ---- pgei_regs.vh ----
// Register map, field layout, reset values and timing counts of the port 0 GPIO block
// Contract
// - Eight-bit port, direction chosen separately for every bit.
// - Direction bit 0 means output, 1 means input; resets to all ones.
// - Output bits drive the pin with the matching output latch bit.
// - Data reads give pin level for inputs, latch value for outputs.
// - Reset makes every bit an input and clears the output latch.
// - Reset disables all edge selects, so no line requests anything.
// - Rising and falling select registers together choose each line's active edge.
// - Rising select bit n enables rising edges; bit 0 non-maskable line, but the mask register masks bit 0 like the others.
// - Direction, data and rising select accept byte and single-bit writes.
// - Bits 5 to 7 pass a digital noise filter before edge detection.
// - Filter takes a new level after three equal consecutive samples.
// - Data register reads show the unfiltered pin level.
// - Bits 0 to 4 need the level held a fixed time first.
// - Falling select register, one bit per line, byte and bit access.
`ifndef PGEI_REGS_VH
`define PGEI_REGS_VH

// Byte addresses
`define PGEI_ADDR_LATCH 32'hFFFFF000
`define PGEI_ADDR_DIR 32'hFFFFF020
`define PGEI_ADDR_FALL 32'hFFFFF0C2
`define PGEI_ADDR_RISE 32'hFFFFF0C0
`define PGEI_ADDR_BITOP 32'hFFFFF0D0
`define PGEI_ADDR_STAT 32'hFFFFF0E0
`define PGEI_ADDR_MASK 32'hFFFFF0E4
`define PGEI_ADDR_PIN 32'hFFFFF0E8

// Bit-operation register fields: [2:0] bit, [5:4] target, [6] value
`define PGEI_BIT_IDX 2:0
`define PGEI_BIT_TGT 5:4
`define PGEI_BIT_VAL 6
`define PGEI_TGT_LATCH 2'h0
`define PGEI_TGT_DIR 2'h1
`define PGEI_TGT_RISE 2'h2
`define PGEI_TGT_FALL 2'h3

// Reset values
`define PGEI_RST_LATCH 8'h00
`define PGEI_RST_DIR 8'hFF
`define PGEI_RST_EDGE 8'h00
`define PGEI_RST_MASK 8'hFF

// Timing
`define PGEI_CLK_NS 10
`define PGEI_FILT_SAMPLES 3
`define PGEI_QUAL_NS 100
`define PGEI_QUAL_CYC ((`PGEI_QUAL_NS + `PGEI_CLK_NS - 1) / `PGEI_CLK_NS)

`endif

// ---- pgei_filter.v ----
// Level qualifier: accepts a new input level after it holds for a set number of clocks
`timescale 1ns/100ps
module pgei_filter #(
   parameter COUNT = 3,
   parameter CW = 8
) (
   // Clock and reset
   input wire i_core_clk,
   input wire i_rst,
   // Sample enable and raw level
   input wire i_sample_en,
   input wire i_level,
   // Accepted level
   output reg o_level
);

   reg [CW-1:0] run_reg;
   reg init_reg;

   // Count consecutive samples differing from accepted level
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         run_reg <= {CW{1'b0}};
         init_reg <= 1'b1;
         o_level <= i_level;
      end else if (init_reg) begin
         o_level <= i_level;
         init_reg <= 1'b0;
      end else if (i_sample_en) begin
         if (i_level == o_level) begin
            run_reg <= {CW{1'b0}};
         end else if (run_reg == COUNT - 1) begin
            o_level <= i_level;
            run_reg <= {CW{1'b0}};
         end else begin
            run_reg <= run_reg + 1'b1;
         end
      end
   end

endmodule

// ---- pgei_edge.v ----
// Edge detector with separate rising and falling enables producing one-clock pulses
`timescale 1ns/100ps
module pgei_edge (
   // Clock and reset
   input wire i_core_clk,
   input wire i_rst,
   // Qualified level and edge selects
   input wire i_level,
   input wire i_rise_en,
   input wire i_fall_en,
   // Request pulse
   output wire o_req
);

   reg prev_reg;
   reg init_reg;

   // Previous level, primed after reset
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         prev_reg <= 1'b0;
         init_reg <= 1'b1;
      end else begin
         prev_reg <= i_level;
         init_reg <= 1'b0;
      end
   end

   // Either selected edge requests
   assign o_req = ~init_reg & ((i_rise_en & i_level & ~prev_reg) |
      (i_fall_en & ~i_level & prev_reg));

endmodule

// ---- pgei_port0.v ----
// Port 0 GPIO with edge-selected interrupt lines and Wishbone register access
`timescale 1ns/100ps
`include "pgei_regs.vh"
module pgei_port0 #(
   parameter QUAL_CYC = `PGEI_QUAL_CYC,
   parameter FILT_SAMPLES = `PGEI_FILT_SAMPLES
) (
   // Clock and reset
   input wire i_core_clk,
   input wire i_rst,
   // Wishbone slave
   input wire i_wb_cyc,
   input wire i_wb_stb,
   input wire i_wb_we,
   input wire [31:0] i_wb_adr,
   input wire [31:0] i_wb_dat,
   input wire [3:0] i_wb_sel,
   output reg [31:0] o_wb_dat,
   output reg o_wb_ack,
   // Port pins
   input wire [7:0] i_pin,
   output wire [7:0] o_pin,
   output wire [7:0] o_pin_oe_n,
   // Interrupt outputs
   output wire [7:0] o_irq_req,
   output wire o_irq
);

   // Registers
   reg [7:0] port0_output_latch_reg;
   reg [7:0] port0_direction_reg;
   reg [7:0] rise_edge_select_reg;
   reg [7:0] fall_edge_select_reg;
   reg [7:0] irq_status_reg;
   reg [7:0] irq_mask_reg;
   reg [7:0] rd_next;
   wire [7:0] qual_level;
   wire [7:0] port_view;
   wire wb_req;
   wire wr_en;
   wire [7:0] wdat;
   wire [7:0] bit_sel;
   wire bit_val;
   wire [1:0] bit_tgt;
   wire do_bitop;

   // Selects one-hot bit position
   function [7:0] pgei_onehot;
      input [2:0] idx;
      begin
         pgei_onehot = 8'h01 << idx;
      end
   endfunction

   // Applies a byte or single-bit update to a register
   function [7:0] pgei_upd;
      input [7:0] cur;
      input byte_wr;
      input [7:0] bdat;
      input bit_wr;
      input [7:0] mask;
      input val;
      begin
         if (byte_wr) begin
            pgei_upd = bdat;
         end else if (bit_wr) begin
            pgei_upd = val ? (cur | mask) : (cur & ~mask);
         end else begin
            pgei_upd = cur;
         end
      end
   endfunction

   // Bus request decode
   assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
   assign wr_en = wb_req & i_wb_we & i_wb_sel[0];
   assign wdat = i_wb_dat[7:0];
   assign do_bitop = wr_en & (i_wb_adr == `PGEI_ADDR_BITOP);
   assign bit_sel = pgei_onehot(i_wb_dat[`PGEI_BIT_IDX]);
   assign bit_val = i_wb_dat[`PGEI_BIT_VAL];
   assign bit_tgt = i_wb_dat[`PGEI_BIT_TGT];

   // Pin drive: output-mode bits drive latch value
   assign o_pin = port0_output_latch_reg;
   assign o_pin_oe_n = port0_direction_reg;

   // Data view: raw pin for inputs, latch for outputs
   assign port_view = (i_pin & port0_direction_reg) |
      (port0_output_latch_reg & ~port0_direction_reg);

   // Writable registers, byte or single-bit access; mask register byte writes only
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         port0_output_latch_reg <= `PGEI_RST_LATCH;
         port0_direction_reg <= `PGEI_RST_DIR;
         rise_edge_select_reg <= `PGEI_RST_EDGE;
         fall_edge_select_reg <= `PGEI_RST_EDGE;
         irq_mask_reg <= `PGEI_RST_MASK;
      end else begin
         port0_output_latch_reg <= pgei_upd(port0_output_latch_reg,
            wr_en & (i_wb_adr == `PGEI_ADDR_LATCH), wdat,
            do_bitop & (bit_tgt == `PGEI_TGT_LATCH), bit_sel, bit_val);
         port0_direction_reg <= pgei_upd(port0_direction_reg,
            wr_en & (i_wb_adr == `PGEI_ADDR_DIR), wdat,
            do_bitop & (bit_tgt == `PGEI_TGT_DIR), bit_sel, bit_val);
         rise_edge_select_reg <= pgei_upd(rise_edge_select_reg,
            wr_en & (i_wb_adr == `PGEI_ADDR_RISE), wdat,
            do_bitop & (bit_tgt == `PGEI_TGT_RISE), bit_sel, bit_val);
         fall_edge_select_reg <= pgei_upd(fall_edge_select_reg,
            wr_en & (i_wb_adr == `PGEI_ADDR_FALL), wdat,
            do_bitop & (bit_tgt == `PGEI_TGT_FALL), bit_sel, bit_val);
         if (wr_en & (i_wb_adr == `PGEI_ADDR_MASK)) begin
            irq_mask_reg <= wdat;
         end
      end
   end

   // Qualifier per line: long hold on bits 0-4, three samples on 5-7
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_line
         if (g < 5) begin : g_slow
            pgei_filter #(
               .COUNT(QUAL_CYC),
               .CW(16)
            ) u_filt (
               .i_core_clk(i_core_clk),
               .i_rst(i_rst),
               .i_sample_en(1'b1),
               .i_level(i_pin[g]),
               .o_level(qual_level[g])
            );
         end else begin : g_fast
            pgei_filter #(
               .COUNT(FILT_SAMPLES),
               .CW(8)
            ) u_filt (
               .i_core_clk(i_core_clk),
               .i_rst(i_rst),
               .i_sample_en(1'b1),
               .i_level(i_pin[g]),
               .o_level(qual_level[g])
            );
         end
         pgei_edge u_edge (
            .i_core_clk(i_core_clk),
            .i_rst(i_rst),
            .i_level(qual_level[g]),
            .i_rise_en(rise_edge_select_reg[g]),
            .i_fall_en(fall_edge_select_reg[g]),
            .o_req(o_irq_req[g])
         );
      end
   endgenerate

   // Sticky status: set wins over write-one-to-clear
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         irq_status_reg <= 8'h00;
      end else if (wr_en & (i_wb_adr == `PGEI_ADDR_STAT)) begin
         irq_status_reg <= (irq_status_reg & ~wdat) | o_irq_req;
      end else begin
         irq_status_reg <= irq_status_reg | o_irq_req;
      end
   end

   // Level interrupt; masking output-mode lines is left to software
   assign o_irq = |(irq_status_reg & ~irq_mask_reg);

   // Read mux
   always @* begin
      case (i_wb_adr)
         `PGEI_ADDR_LATCH: rd_next = port_view;
         `PGEI_ADDR_DIR: rd_next = port0_direction_reg;
         `PGEI_ADDR_RISE: rd_next = rise_edge_select_reg;
         `PGEI_ADDR_FALL: rd_next = fall_edge_select_reg;
         `PGEI_ADDR_STAT: rd_next = irq_status_reg;
         `PGEI_ADDR_MASK: rd_next = irq_mask_reg;
         `PGEI_ADDR_PIN: rd_next = qual_level;
         default: rd_next = 8'h00;
      endcase
   end

   // Ack one cycle after request, read data registered
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h00000000;
      end else begin
         o_wb_ack <= wb_req;
         if (wb_req & ~i_wb_we) begin
            o_wb_dat <= {24'h000000, rd_next};
         end
      end
   end

endmodule

// ---- pgei_port0_props.sv ----
// Port-level assertions for the port 0 GPIO block
`timescale 1ns/100ps
module pgei_port0_props #(
   parameter QUAL_CYC = 10,
   parameter FILT_SAMPLES = 3
) (
   // Observed ports
   input wire i_core_clk,
   input wire i_rst,
   input wire i_wb_cyc,
   input wire i_wb_stb,
   input wire i_wb_we,
   input wire [31:0] i_wb_adr,
   input wire [31:0] i_wb_dat,
   input wire [3:0] i_wb_sel,
   input wire [31:0] o_wb_dat,
   input wire o_wb_ack,
   input wire [7:0] i_pin,
   input wire [7:0] o_pin,
   input wire [7:0] o_pin_oe_n,
   input wire [7:0] o_irq_req,
   input wire o_irq
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);
   // Request taken, then ack for exactly one cycle
   sequence s_take;
      i_wb_cyc && i_wb_stb && !o_wb_ack;
   endsequence
   sequence s_ack_once;
      o_wb_ack ##1 !o_wb_ack;
   endsequence
   a_ack_single: assert property (s_take |=> s_ack_once)
      else $error("ack not single");
   a_rst_state: assert property (disable iff (1'b0)
      i_rst |=> o_pin_oe_n == 8'hFF && o_pin == 8'h00 && o_irq_req == 8'h00 && !o_irq)
      else $error("reset state wrong");
   a_unmapped_zero: assert property (
      s_take ##0 (!i_wb_we && i_wb_adr == 32'hFFFFF004) |=> o_wb_dat == 32'h0)
      else $error("unmapped read not zero");
   a_dat_upper: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h0)
      else $error("read upper bits set");
   a_req_single: assert property (
      |o_irq_req |=> (o_irq_req & $past(o_irq_req)) == 8'h00)
      else $error("request pulse too long");
   a_filt_three: assert property (
      o_irq_req[5] |-> $past(i_pin[5], 2) == $past(i_pin[5], 3))
      else $error("filtered request on unstable pin");
   a_drive_write: assert property (
      !$stable({o_pin, o_pin_oe_n}) |-> o_wb_ack || $past(o_wb_ack))
      else $error("drive changed without write");
   a_irq_cause: assert property (
      $rose(o_irq) |-> o_wb_ack || $past(|o_irq_req))
      else $error("interrupt without request");
endmodule
bind pgei_port0 pgei_port0_props #(.QUAL_CYC(QUAL_CYC), .FILT_SAMPLES(FILT_SAMPLES))
   i_pgei_port0_props (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc),
   .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat),
   .i_wb_sel(i_wb_sel), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_pin(i_pin),
   .o_pin(o_pin), .o_pin_oe_n(o_pin_oe_n), .o_irq_req(o_irq_req), .o_irq(o_irq));

// ---- pgei_pins.sv ----
// Board model resolving the port 0 pins
`timescale 1ns/100ps
module pgei_pins (
   // Board levels and port drive
   input wire [7:0] i_ext,
   input wire [7:0] i_drv,
   input wire [7:0] i_drv_oe_n,
   // Resolved pin levels
   output wire [7:0] o_level
);
   // Port drives enabled bits, board holds the rest steady
   assign o_level = (i_drv & ~i_drv_oe_n) | (i_ext & i_drv_oe_n);
endmodule

// ---- port0_gpio_edge_irq_tb_top.sv ----
// Self-checking bench for the port 0 GPIO block
`timescale 1ns/100ps
`include "pgei_regs.vh"
module port0_gpio_edge_irq_tb_top;
   reg i_core_clk = 1'b0;
   reg i_rst = 1'b1;
   reg cyc = 1'b0;
   reg we = 1'b0;
   reg [31:0] adr = 32'h0;
   reg [31:0] wdat = 32'h0;
   reg [3:0] sel = 4'hF;
   reg [7:0] ext = 8'h5A;
   reg [31:0] d;
   wire [31:0] rdat;
   wire ack;
   wire irq;
   wire [7:0] pin;
   wire [7:0] opin;
   wire [7:0] oe_n;
   wire [7:0] req;
   integer n_errors = 0;
   integer tests_run = 0;
   integer n0 = 0;
   integer n5 = 0;
   // Design with a short qualification time, and the board
   pgei_port0 #(.QUAL_CYC(4)) i_pgei_port0 (.i_core_clk(i_core_clk), .i_rst(i_rst),
      .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat),
      .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack), .i_pin(pin), .o_pin(opin),
      .o_pin_oe_n(oe_n), .o_irq_req(req), .o_irq(irq));
   pgei_pins i_pgei_pins (.i_ext(ext), .i_drv(opin), .i_drv_oe_n(oe_n), .o_level(pin));
   // Clock and request pulse tallies
   always #5 i_core_clk = ~i_core_clk;
   always @(posedge i_core_clk) begin
      n0 <= n0 + req[0];
      n5 <= n5 + req[5];
   end
   task chk(input [31:0] s, input [31:0] e);
      begin
         tests_run = tests_run + 1;
         if (s !== e) begin
            n_errors = n_errors + 1;
            $display("mismatch at %0t: %h not %h", $time, s, e);
         end
      end
   endtask
   // Classic single bus cycle
   task wb(input w, input [31:0] a, input [7:0] v, input [3:0] s);
      begin
         cyc <= 1'b1;
         we <= w;
         adr <= a;
         wdat <= {24'h0, v};
         sel <= s;
         @(posedge i_core_clk);
         while (ack !== 1'b1) begin
            @(posedge i_core_clk);
         end
         d = rdat;
         cyc <= 1'b0;
         @(posedge i_core_clk);
      end
   endtask
   task wr(input [31:0] a, input [7:0] v);
      wb(1'b1, a, v, 4'hF);
   endtask
   task rc(input [31:0] a, input [7:0] e);
      begin
         wb(1'b0, a, 8'h00, 4'hF);
         chk(d, {24'h0, e});
      end
   endtask
   task tick(input integer n);
      repeat (n) @(posedge i_core_clk);
   endtask
   task t_reset;
      begin
         chk({15'h0, irq, oe_n, opin}, 32'h0000FF00);
         rc(`PGEI_ADDR_DIR, 8'hFF);
         rc(`PGEI_ADDR_RISE, 8'h00);
         rc(`PGEI_ADDR_FALL, 8'h00);
         rc(`PGEI_ADDR_LATCH, 8'h5A);
      end
   endtask
   // Output drive, mixed read-back, bit writes, ignored and unmapped cycles
   task t_out;
      begin
         wr(`PGEI_ADDR_DIR, 8'h0F);
         wr(`PGEI_ADDR_LATCH, 8'hC3);
         chk({16'h0, oe_n, opin}, 32'h00000FC3);
         rc(`PGEI_ADDR_LATCH, 8'hCA);
         wr(`PGEI_ADDR_BITOP, 8'h57);
         wr(`PGEI_ADDR_BITOP, 8'h00);
         wb(1'b1, `PGEI_ADDR_DIR, 8'hFF, 4'h0);
         rc(`PGEI_ADDR_DIR, 8'h8F);
         chk({24'h0, opin}, 32'h000000C2);
         rc(32'hFFFFF004, 8'h00);
         wr(`PGEI_ADDR_DIR, 8'hFF);
      end
   endtask
   // Filtered edges on pin 5 with status, mask and clear
   task t_filt;
      begin
         wr(`PGEI_ADDR_MASK, 8'h00);
         wr(`PGEI_ADDR_BITOP, 8'h65);
         rc(`PGEI_ADDR_RISE, 8'h20);
         wr(`PGEI_ADDR_FALL, 8'h20);
         ext <= 8'h7A;
         tick(1);
         ext <= 8'h5A;
         tick(8);
         chk(n5, 0);
         ext <= 8'h7A;
         rc(`PGEI_ADDR_LATCH, 8'h7A);
         tick(4);
         chk({n5[30:0], irq}, 32'h3);
         rc(`PGEI_ADDR_STAT, 8'h20);
         wr(`PGEI_ADDR_STAT, 8'h20);
         wr(`PGEI_ADDR_MASK, 8'h20);
         rc(`PGEI_ADDR_MASK, 8'h20);
         ext <= 8'h5A;
         rc(`PGEI_ADDR_PIN, 8'h7A);
         tick(8);
         chk({n5[30:0], irq}, 32'h4);
         rc(`PGEI_ADDR_STAT, 8'h20);
         wr(`PGEI_ADDR_STAT, 8'h20);
         wr(`PGEI_ADDR_MASK, 8'h00);
         chk({31'h0, irq}, 32'h0);
      end
   endtask
   // Qualified rising edges on pin 0
   task t_qual;
      begin
         wr(`PGEI_ADDR_RISE, 8'h01);
         wr(`PGEI_ADDR_BITOP, 8'h35);
         rc(`PGEI_ADDR_FALL, 8'h00);
         ext <= 8'h5B;
         tick(2);
         ext <= 8'h5A;
         tick(10);
         chk(n0, 0);
         ext <= 8'h5B;
         tick(10);
         ext <= 8'h5A;
         tick(10);
         chk(n0, 1);
      end
   endtask
   // Second reset, edge selects written at the first edge after release
   task t_rst2;
      begin
         i_rst <= 1'b1;
         tick(2);
         i_rst <= 1'b0;
         wr(`PGEI_ADDR_RISE, 8'hFF);
         tick(4);
         rc(`PGEI_ADDR_STAT, 8'h00);
         rc(`PGEI_ADDR_RISE, 8'hFF);
      end
   endtask
   task end_sim;
      begin
         if (n_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
         end else begin
            $display("STATUS NOT OK");
         end
         $finish;
      end
   endtask
   // Main sequence
   initial begin
      tick(2);
      i_rst <= 1'b0;
      tick(1);
      t_reset;
      t_out;
      t_filt;
      t_qual;
      t_rst2;
      end_sim;
   end
   // Watchdog
   initial begin
      tick(3000);
      n_errors = n_errors + 1;
      end_sim;
   end
endmodule
